// [bench/lane_packer_monitor.sv]
/*
  Port checker for the lane packer: framing, lane masks, stamps, pacing.
  Assumes it is bound onto every lane_packer instance.
*/
`default_nettype none

module lane_packer_monitor #(
  parameter int IDLE_PERIOD = lane_packer_pkg::IDLE_PERIOD_SYMS
) (
  // clock, reset and status
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_video_on,
  input wire logic i_audio_on,
  input wire logic i_depth_cfg,
  input wire logic i_pix_valid,
  // outputs watched
  input wire logic o_pix_ready,
  input wire logic [31:0] o_lane_sym,
  input wire logic [3:0] o_lane_ctrl,
  input wire logic [3:0] o_lane_en
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  logic bs;
  logic off_q;
  logic [15:0] cnt_q;
  logic [31:0] m32;
  // blanking start seen on lane 0, and the symbol bits of enabled lanes
  assign bs = o_lane_ctrl[0] &&
    o_lane_sym[7:0] == lane_packer_pkg::BLANKING_START_SYM;
  assign m32 = {{8{o_lane_en[3]}}, {8{o_lane_en[2]}},
    {8{o_lane_en[1]}}, {8{o_lane_en[0]}}};
  // cycles since the last blanking start
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || bs) cnt_q <= 16'h0000;
    else if (cnt_q != 16'hFFFF) cnt_q <= cnt_q + 16'h0001;
  end
  // video has stayed off since a blanking start
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || i_video_on) off_q <= 1'b0;
    else if (bs) off_q <= 1'b1;
  end
  property p_mask; !$past(i_rst) |-> o_lane_en inside {4'h1, 4'h3, 4'hF};
  endproperty
  a_mask: assert property (p_mask)
    else $error("bad lane mask");
  property p_quiet; (o_lane_ctrl & ~o_lane_en) == 4'h0 &&
    (o_lane_sym & ~m32) == 32'h0; endproperty
  a_quiet: assert property (p_quiet)
    else $error("unused lane busy");
  property p_all; |o_lane_ctrl |-> o_lane_ctrl == o_lane_en; endproperty
  a_all: assert property (p_all)
    else $error("ctrl not on all lanes");
  property p_hdr; bs |=> (o_lane_ctrl == 4'h0) [*3]; endproperty
  a_hdr: assert property (p_hdr)
    else $error("header broken");
  property p_novid; bs && !i_video_on |=> o_lane_sym[3] && o_lane_sym[0];
  endproperty
  a_novid: assert property (p_novid)
    else $error("no video flag");
  property p_vst; bs && !i_video_on |-> ##2 o_lane_sym[7:0] == 8'h00;
  endproperty
  a_vst: assert property (p_vst)
    else $error("video stamp not 00");
  property p_ast; bs && !i_audio_on |-> ##3 o_lane_sym[7:0] == 8'h00;
  endproperty
  a_ast: assert property (p_ast)
    else $error("audio stamp not 00");
  property p_period; off_q |-> (bs ? cnt_q == IDLE_PERIOD - 1 :
    cnt_q < IDLE_PERIOD - 1); endproperty
  a_period: assert property (p_period)
    else $error("idle period");
  property p_pace; o_pix_ready && i_pix_valid && !i_depth_cfg |=>
    !o_pix_ready [*2]; endproperty
  a_pace: assert property (p_pace)
    else $error("pixel pace");
endmodule

bind lane_packer lane_packer_monitor #(.IDLE_PERIOD(IDLE_PERIOD)) mon_u (.*);

`default_nettype wire

// [bench/lane_sink_model.sv]
/*
  Sink side model: records every lane row from the first framing
  symbol on lane 0 while armed. Assumes the single symbol clock.
*/
`default_nettype none

module lane_sink_model (
  // clock and capture arm
  input wire logic i_sys_clk,
  input wire logic i_arm,
  // lanes from the packer
  input wire logic [31:0] i_lane_sym,
  input wire logic [3:0] i_lane_ctrl
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [35:0] cap[$];
  logic run = 1'b0;
  // start on a framing symbol, then keep every row
  always @(posedge i_sys_clk) begin
    if (!i_arm) begin
      cap.delete();
      run = 1'b0;
    end else if (run || i_lane_ctrl[0]) begin
      run = 1'b1;
      cap.push_back({i_lane_ctrl, i_lane_sym});
    end
  end
endmodule

`default_nettype wire

// [bench/test_main_link_pixel_lane_packer.sv]
/*
  Testbench for lane_packer: random two-group lines on every lane
  setting at both depths, header-only blank lines, then the idle
  pattern. Assumes the sink
  model records lane rows and the checker is bound.
*/
`default_nettype none

module test_main_link_pixel_lane_packer;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int P = 64;
  logic i_sys_clk = 1'b0, i_rst = 1'b1, i_depth_cfg = 1'b0, arm = 1'b0;
  logic i_video_on = 1'b1, i_audio_on = 1'b0, i_vblank = 1'b0;
  logic i_field_odd = 1'b0, i_interlace = 1'b0, i_audio_mute = 1'b0;
  logic i_blank_line_req = 1'b0, i_pix_valid = 1'b0, i_pix_last = 1'b0;
  logic [1:0] i_lane_cfg = 2'h0;
  logic [7:0] i_video_m = 8'h00, i_audio_m = 8'h00;
  logic [119:0] i_pix_data = 120'h0;
  logic [3:0] i_pix_mask = 4'h0, m1, o_lane_ctrl, o_lane_en;
  logic o_pix_ready, idle = 1'b0, hdr_only = 1'b0;
  logic [31:0] o_lane_sym, seed = 32'h0000001F;
  logic [127:0] px[2];
  int n, d, err_total = 0, compares = 0;

  lane_packer #(.IDLE_PERIOD(P)) dut_u (.*);
  lane_sink_model partner_u (.i_sys_clk, .i_arm(arm),
    .i_lane_sym(o_lane_sym), .i_lane_ctrl(o_lane_ctrl));

  // free running symbol clock
  initial forever #5 i_sys_clk = ~i_sys_clk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // expected lane row c: ctrl flags over the four symbol bytes
  function automatic logic [35:0] row(int c);
    logic [35:0] r;
    logic [63:0] s;
    logic [29:0] p;
    int h;
    r = 36'h0;
    h = c - d - 2;
    for (int k = 0; k < n; k++) begin
      s = 64'h0;
      for (int g = 0; g < 2; g++) begin
        p = (g == 1 && !m1[k]) ? 30'h0 : px[g][30*k +: 30];
        if (i_depth_cfg) s = s | ({34'h0, p} << (34 - 30 * g));
        else s = s | ({40'h0, p[27:20], p[17:10], p[7:0]} << (40 - 24 * g));
      end
      if (c == 0 && d >= 0) begin
        r[32+k] = 1'b1;
        r[8*k +: 8] = lane_packer_pkg::BLANKING_END_SYM;
      end else if (c <= d) r[8*k +: 8] = s[71 - 8*c -: 8];
      else if (c == d + 1 || (idle && c == P)) begin
        r[32+k] = 1'b1;
        r[8*k +: 8] = lane_packer_pkg::BLANKING_START_SYM;
      end else if (h < 12 / n) begin
        r[8*k +: 8] = (h % 3 == 0) ? {3'h0, i_audio_mute, idle, i_interlace,
          i_field_odd & i_interlace, i_vblank | idle} : (h % 3 == 1) ?
          (idle ? 8'h00 : i_video_m) : (i_audio_on ? i_audio_m : 8'h00);
      end
    end
    return r;
  endfunction

  task automatic check(string what, logic [35:0] seen, logic [35:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rows(int cnt);
    logic [35:0] s;
    logic [35:0] e;
    for (int c = 0; c < cnt; c++) begin
      s = partner_u.cap[c];
      e = row(c);
      if (c > 0 && c <= d && i_depth_cfg)
        check("pixel row", s, e);
      else if (c > 0 && c <= d)
        check("pixel row", s, e);
      else if (c <= d + 1)
        check("frame row", s, e);
      else if (idle)
        check("idle row", s, e);
      else
        check("header row", s, e);
    end
    e = {32'h0, (4'h1 << n) - 4'h1};
    check("lane en", {32'h0, o_lane_en}, e);
    arm = 1'b0;
  endtask

  // offer one group and hold it until the packer takes it
  task automatic send(logic [119:0] d, logic [3:0] m, logic l);
    int t;
    t = 0;
    i_pix_valid = 1'b1;
    i_pix_data = d;
    i_pix_mask = m;
    i_pix_last = l;
    while (o_pix_ready !== 1'b1 && t < 200) begin
      @(negedge i_sys_clk);
      t++;
    end
    @(negedge i_sys_clk);
  endtask

  task automatic line(logic [1:0] cfg, logic dep);
    logic [31:0] r;
    r = rnd();
    i_lane_cfg = cfg;
    i_depth_cfg = dep;
    n = cfg == 2'h2 ? 4 : (cfg == 2'h1 ? 2 : 1);
    d = hdr_only ? -1 : (dep ? 8 : 6);
    px[0] = {rnd(), rnd(), rnd(), rnd()};
    px[1] = {rnd(), rnd(), rnd(), rnd()};
    m1 = (4'h1 << (r[31:24] % n + 1)) - 4'h1;
    {i_audio_on, i_vblank, i_field_odd, i_interlace} = r[11:8];
    i_audio_mute = r[12];
    i_video_m = r[7:0];
    i_audio_m = r[23:16];
    repeat (3) @(negedge i_sys_clk);
    arm = 1'b1;
    if (hdr_only) begin
      // vertical blank line: header only, no pixels
      i_blank_line_req = 1'b1;
      @(negedge i_sys_clk);
      i_blank_line_req = 1'b0;
    end else begin
      send(px[0][119:0], (4'h1 << n) - 4'h1, 1'b0);
      // settings moved mid-line must not reach the lanes
      i_lane_cfg = ~cfg;
      i_depth_cfg = ~dep;
      send(px[1][119:0], m1, 1'b1);
      i_lane_cfg = cfg;
      i_depth_cfg = dep;
      i_pix_valid = 1'b0;
    end
    repeat (40) @(negedge i_sys_clk);
    rows(d + 2 + 12 / n);
  endtask

  task automatic conclude();
    if (err_total == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // main sequence: reset, lines, then the idle pattern
  initial begin
    repeat (8) @(negedge i_sys_clk);
    check("reset", {o_lane_ctrl, o_lane_sym}, 36'h0);
    i_rst = 1'b0;
    for (int k = 0; k < 20; k++) begin
      hdr_only = (k >= 16);
      line(2'(k), k[2]);
    end
    {i_video_on, i_vblank, i_field_odd, i_interlace, i_audio_mute} = 5'h00;
    i_lane_cfg = 2'h2;
    n = 4;
    d = -1;
    idle = 1'b1;
    i_audio_on = seed[3];
    repeat (2) @(negedge i_sys_clk);
    arm = 1'b1;
    repeat (2 * P + 10) @(negedge i_sys_clk);
    rows(P + 1);
    conclude();
  end

  // cut a hung run short well after the sequence should end
  initial begin
    #200us;
    err_total++;
    conclude();
  end
endmodule

`default_nettype wire

// [logic/lane_packer.sv]
/*
  Main-link lane packer: frames a pixel stream onto 1, 2 or 4 lanes,
  one symbol per lane per link symbol clock, with blanking header and
  idle pattern.
  Assumes pixel source and stream status are on i_sys_clk, and the
  physical layer encodes symbols whose control flag is set.
*/
// Functional notes
// [R1] video stamp is low M byte, else 00h
// [R2] audio stamp is low M byte, else 00h
// [R3] no video: header group every 8192 symbols
// [R4] header items appear four times in total
// [R5] every enabled lane sends one symbol each cycle
// [R6] missing last-cycle pixel bits are sent as zeros
// [R7] single lane setting uses lane 0
// [R8] two lane setting uses lanes 0 and 1
// [R9] 8 bpc four lanes: lane k, pixel k+4n
// [R10] 8 bpc two lanes: even lane 0, odd lane 1
// [R11] 8 bpc one lane: all pixels on lane 0
// [R12] YCbCr uses red, green, blue slots as Cr Y Cb
// [R13] 10 bpc components packed MSB first, cut in bytes
// [R14] pixel index modulo lane count picks the lane
// [R15] blanking start then info, video, audio stamps
// [R16] info byte flags; no-video flag in idle pattern
// [R17] lane count and depth change only when idle
// [R18] control flag marks framing symbols per lane
`default_nettype none

module lane_packer #(
  parameter int IDLE_PERIOD = lane_packer_pkg::IDLE_PERIOD_SYMS
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // static configuration
  input wire logic [1:0] i_lane_cfg,
  input wire logic i_depth_cfg,
  // stream status
  input wire logic i_video_on,
  input wire logic i_audio_on,
  input wire logic [7:0] i_video_m,
  input wire logic [7:0] i_audio_m,
  input wire logic i_vblank,
  input wire logic i_field_odd,
  input wire logic i_interlace,
  input wire logic i_audio_mute,
  input wire logic i_blank_line_req,
  // pixel group, pixel k in slice k
  input wire logic i_pix_valid,
  input wire logic [119:0] i_pix_data,
  input wire logic [3:0] i_pix_mask,
  input wire logic i_pix_last,
  output logic o_pix_ready,
  // lanes towards the physical layer
  output logic [31:0] o_lane_sym,
  output logic [3:0] o_lane_ctrl,
  output logic [3:0] o_lane_en
);

  lane_packer_pkg::pack_state_t state_q, state_d;
  lane_packer_pkg::emit_t emit;
  logic [1:0] lanes_q;
  logic depth_q;
  logic [5:0] cnt_q, cnt_d;
  logic done_q, done_d;
  logic [1:0] item_q, item_d;
  logic [1:0] rep_q, rep_d;
  logic [13:0] idle_cnt_q;
  logic ready_d;
  logic take;
  logic ctrl_d;
  logic [3:0] en_mask;
  logic [1:0] last_rep;
  logic [5:0] pix_bits;
  logic [7:0] vbid;
  logic [7:0] hdr_byte;
  logic [31:0] sym_d;
  logic [39:0] buf_q [lane_packer_pkg::MAX_LANES];
  logic [39:0] merged [lane_packer_pkg::MAX_LANES];

  // settings are sampled only between lines
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      lanes_q <= lane_packer_pkg::LANES_1;
      depth_q <= 1'b0;
    end else if (state_q == lane_packer_pkg::ST_IDLE) begin
      lanes_q <= i_lane_cfg; // see [R17]
      depth_q <= i_depth_cfg; // see [R17]
    end
  end

  // lane enables, header repeats and pixel size from the settings
  always_comb begin
    case (lanes_q)
      lane_packer_pkg::LANES_2: begin
        en_mask = lane_packer_pkg::MASK_2; // see [R8]
        last_rep = lane_packer_pkg::LAST_REP_2;
      end
      lane_packer_pkg::LANES_4: begin
        en_mask = lane_packer_pkg::MASK_4;
        last_rep = lane_packer_pkg::LAST_REP_4;
      end
      default: begin
        en_mask = lane_packer_pkg::MASK_1; // see [R7]
        last_rep = lane_packer_pkg::LAST_REP_1; // see [R4]
      end
    endcase
    pix_bits = (depth_q == lane_packer_pkg::DEPTH_10BPC) ?
               lane_packer_pkg::BITS_10BPC : lane_packer_pkg::BITS_8BPC;
  end

  // header bytes sent after blanking start
  always_comb begin
    vbid = 8'h00;
    vbid[lane_packer_pkg::VBID_VBLANK] = i_vblank | ~i_video_on;
    vbid[lane_packer_pkg::VBID_FIELD] =
      i_field_odd & i_interlace & i_video_on;
    vbid[lane_packer_pkg::VBID_INTERLACE] = i_interlace & i_video_on;
    vbid[lane_packer_pkg::VBID_NO_VIDEO] = ~i_video_on; // see [R16]
    vbid[lane_packer_pkg::VBID_MUTE] = i_audio_mute;
    case (item_q)
      lane_packer_pkg::ITEM_VBID: hdr_byte = vbid;
      lane_packer_pkg::ITEM_VSTAMP:
        hdr_byte = i_video_on ? i_video_m : 8'h00; // see [R1]
      lane_packer_pkg::ITEM_ASTAMP:
        hdr_byte = i_audio_on ? i_audio_m : 8'h00; // see [R2]
      default: hdr_byte = 8'h00;
    endcase
  end

  assign take = o_pix_ready & i_pix_valid;

  // framing sequence and shared bit count of the lane buffers
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    done_d = done_q;
    item_d = item_q;
    rep_d = rep_q;
    emit = lane_packer_pkg::EM_DUMMY;
    ctrl_d = 1'b0;
    case (state_q)
      lane_packer_pkg::ST_IDLE: begin
        if (i_video_on && i_pix_valid) begin
          state_d = lane_packer_pkg::ST_BE;
        end else if ((i_video_on && i_blank_line_req) ||
                     (!i_video_on &&
                      idle_cnt_q >= 14'(IDLE_PERIOD - 2))) begin
          state_d = lane_packer_pkg::ST_BS; // see [R3]
        end
      end
      lane_packer_pkg::ST_BE: begin
        emit = lane_packer_pkg::EM_BE;
        ctrl_d = 1'b1; // see [R18]
        cnt_d = lane_packer_pkg::CNT_RESET;
        done_d = 1'b0;
        state_d = lane_packer_pkg::ST_DATA;
      end
      lane_packer_pkg::ST_DATA: begin
        if (cnt_q >= lane_packer_pkg::SYM_BITS) begin
          emit = lane_packer_pkg::EM_BUF;
          cnt_d = cnt_q - lane_packer_pkg::SYM_BITS;
        end else if (take) begin
          emit = lane_packer_pkg::EM_MERGED;
          cnt_d = cnt_q + pix_bits - lane_packer_pkg::SYM_BITS;
          done_d = i_pix_last;
        end else if (done_q) begin
          emit = lane_packer_pkg::EM_BUF; // see [R6]
          cnt_d = lane_packer_pkg::CNT_RESET;
        end else begin
          emit = lane_packer_pkg::EM_ZERO; // source underrun filler
        end
        if (done_d && cnt_d == lane_packer_pkg::CNT_RESET) begin
          state_d = lane_packer_pkg::ST_BS; // see [R15]
        end
      end
      lane_packer_pkg::ST_BS: begin
        emit = lane_packer_pkg::EM_BS;
        ctrl_d = 1'b1; // see [R18]
        item_d = lane_packer_pkg::ITEM_VBID;
        rep_d = 2'h0;
        state_d = lane_packer_pkg::ST_HDR;
      end
      lane_packer_pkg::ST_HDR: begin
        emit = lane_packer_pkg::EM_HDR; // see [R15]
        if (item_q == lane_packer_pkg::ITEM_ASTAMP) begin
          item_d = lane_packer_pkg::ITEM_VBID;
          rep_d = rep_q + 2'h1;
          if (rep_q == last_rep) begin
            state_d = lane_packer_pkg::ST_IDLE; // see [R4]
          end
        end else begin
          item_d = item_q + 2'h1;
        end
      end
      default: state_d = lane_packer_pkg::ST_IDLE;
    endcase
    ready_d = (state_d == lane_packer_pkg::ST_DATA) && !done_d &&
              (cnt_d < lane_packer_pkg::SYM_BITS);
  end

  // sequence registers
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_q <= lane_packer_pkg::ST_IDLE;
      cnt_q <= lane_packer_pkg::CNT_RESET;
      done_q <= 1'b0;
      item_q <= lane_packer_pkg::ITEM_VBID;
      rep_q <= 2'h0;
      o_pix_ready <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      done_q <= done_d;
      item_q <= item_d;
      rep_q <= rep_d;
      o_pix_ready <= ready_d;
    end
  end

  // symbol counter for the idle pattern, restarted at blanking start
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || state_q == lane_packer_pkg::ST_BS) begin
      idle_cnt_q <= lane_packer_pkg::IDLE_CNT_RESET;
    end else begin
      idle_cnt_q <= idle_cnt_q + 14'h0001; // see [R3]
    end
  end

  // one bit-stream buffer per lane; lane k takes pixel k of a group
  for (genvar k = 0; k < lane_packer_pkg::MAX_LANES; k++) begin : g_lane
    logic [29:0] pix;
    logic [39:0] aligned;
    logic [7:0] sym;

    assign pix = i_pix_data[k*lane_packer_pkg::PIX_W +: 30]; // see [R14]

    // left-align the pixel and append it behind the held bits
    always_comb begin
      aligned = '0;
      if (i_pix_mask[k] && en_mask[k]) begin // see [R6]
        if (depth_q == lane_packer_pkg::DEPTH_10BPC) begin
          aligned = {pix, 10'h000}; // see [R13]
        end else begin
          aligned = {pix[27:20], pix[17:10], pix[7:0], 16'h0000}; // see [R9]
        end
      end
      merged[k] = buf_q[k] | (aligned >> cnt_q); // see [R12]
    end

    // shift out one byte per cycle, MSB first
    always_ff @(posedge i_sys_clk) begin
      if (i_rst || state_q == lane_packer_pkg::ST_BE) begin
        buf_q[k] <= '0;
      end else if (emit == lane_packer_pkg::EM_BUF) begin
        buf_q[k] <= buf_q[k] << 8;
      end else if (emit == lane_packer_pkg::EM_MERGED) begin
        buf_q[k] <= merged[k] << 8; // see [R10]
      end
    end

    // symbol for this lane in the current row
    always_comb begin
      case (emit)
        lane_packer_pkg::EM_BE: sym = lane_packer_pkg::BLANKING_END_SYM;
        lane_packer_pkg::EM_BS: sym = lane_packer_pkg::BLANKING_START_SYM;
        lane_packer_pkg::EM_HDR: sym = hdr_byte;
        lane_packer_pkg::EM_BUF: sym = buf_q[k][39:32];
        lane_packer_pkg::EM_MERGED: sym = merged[k][39:32]; // see [R11]
        default: sym = lane_packer_pkg::DUMMY_SYM;
      endcase
    end

    assign sym_d[k*8 +: 8] = en_mask[k] ? sym : 8'h00; // see [R5]
  end

  // registered lane outputs, all lanes updated in the same cycle
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_lane_sym <= 32'h0000_0000;
      o_lane_ctrl <= 4'h0;
      o_lane_en <= 4'h0;
    end else begin
      o_lane_sym <= sym_d; // see [R5]
      o_lane_ctrl <= ctrl_d ? en_mask : 4'h0; // see [R18]
      o_lane_en <= en_mask; // see [R7]
    end
  end

endmodule

`default_nettype wire

// [logic/lane_packer_pkg.sv]
/*
  Constants and types shared by the main-link lane packer.
  Assumes one symbol clock domain; symbol codes of the control
  characters are local tags that the physical layer re-encodes.
*/
`default_nettype none

package lane_packer_pkg;
  // lane geometry
  localparam int MAX_LANES = 4;
  localparam int PIX_W = 30;
  localparam int BUF_W = 40;
  // bits per pixel and per symbol
  localparam logic [5:0] BITS_8BPC = 6'h18;
  localparam logic [5:0] BITS_10BPC = 6'h1E;
  localparam logic [5:0] SYM_BITS = 6'h08;
  // lane count setting
  localparam logic [1:0] LANES_1 = 2'h0;
  localparam logic [1:0] LANES_2 = 2'h1;
  localparam logic [1:0] LANES_4 = 2'h2;
  // lane enable masks
  localparam logic [3:0] MASK_1 = 4'h1;
  localparam logic [3:0] MASK_2 = 4'h3;
  localparam logic [3:0] MASK_4 = 4'hF;
  // header repeats per lane, minus one
  localparam logic [1:0] LAST_REP_1 = 2'h3;
  localparam logic [1:0] LAST_REP_2 = 2'h1;
  localparam logic [1:0] LAST_REP_4 = 2'h0;
  // header items after blanking start
  localparam logic [1:0] ITEM_VBID = 2'h0;
  localparam logic [1:0] ITEM_VSTAMP = 2'h1;
  localparam logic [1:0] ITEM_ASTAMP = 2'h2;
  // depth setting
  localparam logic DEPTH_10BPC = 1'h1;
  // symbol tags (arbitrary values; blanking start and end flagged as control)
  localparam logic [7:0] BLANKING_START_SYM = 8'h01;
  localparam logic [7:0] BLANKING_END_SYM = 8'h02;
  localparam logic [7:0] DUMMY_SYM = 8'h00;
  // video blank info byte fields
  localparam int VBID_VBLANK = 0;
  localparam int VBID_FIELD = 1;
  localparam int VBID_INTERLACE = 2;
  localparam int VBID_NO_VIDEO = 3;
  localparam int VBID_MUTE = 4;
  // idle pattern period in link symbols
  localparam int IDLE_PERIOD_SYMS = 8192;
  // reset values
  localparam logic [5:0] CNT_RESET = 6'h00;
  localparam logic [13:0] IDLE_CNT_RESET = 14'h0000;

  typedef enum {ST_IDLE, ST_BE, ST_DATA, ST_BS, ST_HDR} pack_state_t;
  typedef enum {EM_DUMMY, EM_BE, EM_BS, EM_HDR, EM_BUF, EM_MERGED,
                EM_ZERO} emit_t;
endpackage

`default_nettype wire
